// ### src/rsc_pkg.sv
package rsc_pkg;

   // Byte addresses of the APB registers
   localparam logic [11:0] RSC_ADDR_OPTION = 12'h000;
   localparam logic [11:0] RSC_ADDR_MODE0  = 12'h004;
   localparam logic [11:0] RSC_ADDR_MODE1  = 12'h008;
   localparam logic [11:0] RSC_ADDR_THR0   = 12'h00C;
   localparam logic [11:0] RSC_ADDR_THR1   = 12'h010;
   localparam logic [11:0] RSC_ADDR_DETEN  = 12'h014;
   localparam logic [11:0] RSC_ADDR_STATUS = 12'h018;

   // Printed location of the option byte in flash
   localparam logic [15:0] RSC_OPTION_LOCATION = 16'hFFFF;

   // Field positions
   localparam int RSC_OPT_THR0_DIS_BIT  = 5;
   localparam int RSC_OPT_THR1_DIS_BIT  = 6;
   localparam int RSC_SW_RESET_BIT      = 3;
   localparam int RSC_WDT_SEL_BIT       = 2;
   localparam int RSC_CTRL_A_BIT        = 0;
   localparam int RSC_CTRL_B_BIT        = 6;
   localparam int RSC_DET0_EN_BIT       = 5;
   localparam int RSC_DET1_EN_BIT       = 6;

   // Reset values
   localparam logic [7:0] RSC_THR_CTRL_RST = 8'h00;
   localparam logic [7:0] RSC_DETEN_RST    = 8'h00;
   localparam logic [7:0] RSC_MODE1_RST    = 8'h00;

   // Release count in low-speed oscillator clocks
   localparam int         RSC_RELEASE_CLOCKS = 32;
   localparam logic [5:0] RSC_RELEASE_LAST   = 6'(RSC_RELEASE_CLOCKS);

   // Low-speed oscillator divide for the CPU clock after reset
   localparam logic [1:0] RSC_CPU_DIV8 = 2'h3;

   // Low-speed oscillator: one tick every RSC_LS_TICK_CYCLES of i_clock
   localparam int         RSC_CLOCK_MHZ      = 50;
   localparam int         RSC_LS_OSC_KHZ     = 125;
   localparam int         RSC_LS_TICK_CYCLES = (RSC_CLOCK_MHZ * 1000) / RSC_LS_OSC_KHZ;
   localparam logic [8:0] RSC_LS_TICK_LAST   = 9'(RSC_LS_TICK_CYCLES - 1);

   // Reset cause codes
   localparam logic [2:0] RSC_CAUSE_POWER = 3'h0;
   localparam logic [2:0] RSC_CAUSE_PIN   = 3'h1;
   localparam logic [2:0] RSC_CAUSE_THR0  = 3'h2;
   localparam logic [2:0] RSC_CAUSE_THR1  = 3'h3;
   localparam logic [2:0] RSC_CAUSE_THR2  = 3'h4;
   localparam logic [2:0] RSC_CAUSE_WDT   = 3'h5;
   localparam logic [2:0] RSC_CAUSE_SW    = 3'h6;

   typedef enum logic [1:0] {RSC_ST_HOLD, RSC_ST_COUNT, RSC_ST_RUN} rsc_state_e;

   typedef struct packed {
      logic thr0_low;
      logic thr1_low;
      logic thr2_low;
      logic pin_low;
   } rsc_supply_s;

   typedef struct packed {
      logic [7:0] rdata;
      logic       slverr;
   } rsc_rd_s;

endpackage

// ### src/rsc_sync.sv
`timescale 1ns/1ps
`default_nettype none

// Two-flop synchroniser for the pin and comparator levels
module rsc_sync
   import rsc_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_reset_n,
   input  wire rsc_supply_s i_async,
   output var  rsc_supply_s o_sync
);

   typedef struct packed {
      rsc_supply_s meta;
      rsc_supply_s stable;
   } rsc_sync_s;

   rsc_sync_s st_r;
   rsc_sync_s st_nxt;

   always_comb
   begin
      st_nxt.meta   = i_async;
      st_nxt.stable = st_r.meta;
   end

   // Low-side levels reset to asserted so the core starts in reset
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         st_r <= '{meta: 4'hF, stable: 4'hF};
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign o_sync = st_r.stable;

endmodule

`default_nettype wire

// ### src/rsc_reset_ctrl.sv
// Function
// [RL1] Power-up: after supply passes threshold, count 32 slow clocks, then release reset.
// [RL2] After any reset, CPU clock select becomes slow oscillator divided by 8.
// [RL3] Threshold-0 reset is enabled after power-on reset unless option disables it. The code enables it on the first variant only.
// [RL4] Supply at or below threshold 0 holds pins, CPU and registers in reset.
// [RL5] Recovery above threshold 0 counts 32 slow clocks before release.
// [RL6] Threshold-0 enable is option bit 5, latched at hardware reset, read-only.
// [RL7] Software sets option bit 0 and threshold-0 control and enable bits.
// [RL8] Supply-monitor resets leave RAM untouched; RAM undefined if written during drop.
// [RL9] Threshold-1 reset on first variant resets most state, then runs from vector.
// [RL10] Second variant: threshold-1 low resets; recovery counts 32 slow clocks.
// [RL11] Threshold-1 enable is option bit 6, latched at hardware reset, read-only.
// [RL12] Software sets option bit 0 and threshold-1 control and enable bits.
// [RL13] Supply at or below threshold 2 resets, then runs from vector.
// [RL14] Watchdog underflow resets when the watchdog-reset select bit is 1.
// [RL15] Watchdog reset leaves RAM and retained registers uncleared.
// [RL16] Writing 1 to the software-reset bit resets and restarts at the vector.
// [RL17] Software reset keeps retained registers and does not clear RAM.
// [RL18] Low reset pin resets everything; rising edge restarts at the vector. The code keeps retained registers on a pin reset.
// [RL19] All enabled sources merge into one reset held until release condition.
// [RL20] Release counter restarts from zero if a supply source reasserts.
//
// The APB slave port was left to the implementer.
`timescale 1ns/1ps
`default_nettype none

module rsc_reset_ctrl
   import rsc_pkg::*;
(
   input  wire logic        i_clock,
   input  wire logic        i_reset_n,
   input  wire logic        i_variant_second,
   input  wire logic [7:0]  i_option_byte,
   input  wire logic        i_reset_pin_n,
   input  wire logic        i_thr0_low,
   input  wire logic        i_thr1_low,
   input  wire logic        i_thr2_low,
   input  wire logic        i_wdt_underflow,
   input  wire logic        i_wdt_clear,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic             pready,
   output logic [31:0]      prdata,
   output logic             pslverr,
   output logic             o_core_reset_n,
   output logic             o_retain_reset_n,
   output logic [1:0]       o_cpu_clock_div
);

   rsc_supply_s sup_async;
   rsc_supply_s sup;

   assign sup_async = '{thr0_low: i_thr0_low, thr1_low: i_thr1_low,
                        thr2_low: i_thr2_low, pin_low: ~i_reset_pin_n};

   rsc_sync u_sync
   (
      .i_clock   (i_clock),
      .i_reset_n (i_reset_n),
      .i_async   (sup_async),
      .o_sync    (sup)
   );

   typedef struct packed {
      rsc_state_e state;
      logic [8:0] tick_cnt;
      logic [5:0] rel_cnt;
      logic       opt_valid;
      logic [7:0] option;
      logic [7:0] thr0_ctrl;
      logic [7:0] thr1_ctrl;
      logic [7:0] det_en;
      logic [7:0] mode1;
      logic       sw_req;
      logic       wdt_req;
      logic       wdt_lat;
      logic [2:0] cause;
      logic       core_rst_n;
      logic       retain_rst_n;
      logic [1:0] cpu_div;
      logic       pready;
      logic       pslverr;
      logic [31:0] prdata;
   } rsc_core_s;

   rsc_core_s st_r;
   rsc_core_s st_nxt;

   logic    thr0_armed;
   logic    thr1_armed;
   logic    thr1_vm_armed;
   logic    supply_hold;
   logic    apb_done;
   logic    wdt_set;
   logic    held;
   logic    ls_tick;
   logic    apb_acc;
   rsc_rd_s rd;

   always_comb
   begin
      // Option enables take effect only once latched at hardware reset
      thr0_armed = st_r.opt_valid & ~i_variant_second
                   & ~st_r.option[RSC_OPT_THR0_DIS_BIT];            // RL3 RL6
      thr1_armed = st_r.opt_valid & i_variant_second
                   & ~st_r.option[RSC_OPT_THR1_DIS_BIT];            // RL11
      // First variant: threshold-1 reset is armed by the software control bits
      thr1_vm_armed = st_r.opt_valid & ~i_variant_second
                      & st_r.thr1_ctrl[RSC_CTRL_A_BIT] & st_r.thr1_ctrl[RSC_CTRL_B_BIT]
                      & st_r.det_en[RSC_DET1_EN_BIT];               // RL9
      supply_hold = (thr0_armed & sup.thr0_low)                     // RL4
                  | (thr1_armed & sup.thr1_low);                    // RL10
      // Any active source holds the CPU in reset
      held = ~st_r.opt_valid | supply_hold | sup.pin_low            // RL19 RL18
           | (thr1_vm_armed & sup.thr1_low)                         // RL9
           | sup.thr2_low | st_r.sw_req | st_r.wdt_req;             // RL13 RL16 RL14
      ls_tick = (st_r.tick_cnt == RSC_LS_TICK_LAST);
      apb_acc = psel & penable & ~st_r.pready;
      // Writes land at the edge that completes the transfer
      apb_done = psel & penable & st_r.pready;
      wdt_set  = i_wdt_underflow & ~st_r.wdt_lat & st_r.mode1[RSC_WDT_SEL_BIT];

      rd.rdata  = 8'h00;
      rd.slverr = 1'b0;
      case (paddr)
         RSC_ADDR_OPTION: rd.rdata = st_r.option;
         RSC_ADDR_MODE0:  rd.rdata = 8'h00;
         RSC_ADDR_MODE1:  rd.rdata = st_r.mode1;
         RSC_ADDR_THR0:   rd.rdata = st_r.thr0_ctrl;
         RSC_ADDR_THR1:   rd.rdata = st_r.thr1_ctrl;
         RSC_ADDR_DETEN:  rd.rdata = st_r.det_en;
         RSC_ADDR_STATUS: rd.rdata = {3'h0, sup.thr0_low, sup.thr1_low, st_r.cause};
         default:         rd.slverr = 1'b1;
      endcase

      st_nxt          = st_r;
      st_nxt.retain_rst_n = 1'b1;
      st_nxt.pready   = apb_acc;
      st_nxt.pslverr  = apb_acc & rd.slverr;
      st_nxt.prdata   = (apb_acc & ~pwrite) ? {24'h0, rd.rdata} : 32'h0;
      st_nxt.tick_cnt = ls_tick ? 9'h000 : st_r.tick_cnt + 9'h001;

      // Option byte is sampled once, just after hardware reset release
      if (!st_r.opt_valid)
      begin
         st_nxt.opt_valid = 1'b1;
         st_nxt.option    = i_option_byte;                          // RL6 RL11
      end

      st_nxt.wdt_lat = i_wdt_underflow;
      if (wdt_set)
      begin
         st_nxt.wdt_req = 1'b1;                                     // RL14
      end

      if (apb_done & pwrite & st_r.core_rst_n)
      begin
         case (paddr)
            RSC_ADDR_MODE0:
            begin
               if (pwdata[RSC_SW_RESET_BIT])
               begin
                  st_nxt.sw_req = 1'b1;                             // RL16
               end
            end
            RSC_ADDR_MODE1: st_nxt.mode1 = pwdata[7:0];
            RSC_ADDR_THR0:  st_nxt.thr0_ctrl = pwdata[7:0];
            RSC_ADDR_THR1:  st_nxt.thr1_ctrl = pwdata[7:0];
            RSC_ADDR_DETEN: st_nxt.det_en = pwdata[7:0];
            default:        st_nxt.sw_req = st_r.sw_req;
         endcase
      end

      case (st_r.state)
         RSC_ST_RUN:
         begin
            if (held)
            begin
               st_nxt.state      = RSC_ST_HOLD;
               st_nxt.core_rst_n = 1'b0;
               // RAM and retained registers stay intact on these resets
               st_nxt.retain_rst_n = 1'b1;                          // RL8 RL15 RL17
               if (sup.pin_low)
               begin
                  st_nxt.cause = RSC_CAUSE_PIN;
               end
               else if (supply_hold)
               begin
                  st_nxt.cause = sup.thr0_low & thr0_armed ? RSC_CAUSE_THR0
                                                           : RSC_CAUSE_THR1;
               end
               else if (thr1_vm_armed & sup.thr1_low)
               begin
                  st_nxt.cause = RSC_CAUSE_THR1;                    // RL9
               end
               else if (sup.thr2_low)
               begin
                  st_nxt.cause = RSC_CAUSE_THR2;
               end
               else if (st_r.wdt_req)
               begin
                  st_nxt.cause = RSC_CAUSE_WDT;
               end
               else
               begin
                  st_nxt.cause = RSC_CAUSE_SW;
               end
            end
         end
         RSC_ST_HOLD:
         begin
            st_nxt.core_rst_n = 1'b0;
            st_nxt.sw_req     = 1'b0;
            // A new underflow in the same cycle outlives the clear
            st_nxt.wdt_req    = (st_r.wdt_req & ~i_wdt_clear) | wdt_set;
            st_nxt.rel_cnt    = 6'h00;
            st_nxt.cpu_div    = RSC_CPU_DIV8;                       // RL2
            st_nxt.mode1      = RSC_MODE1_RST;
            if (!held)
            begin
               // Power, threshold-0 and second-variant threshold-1 causes wait for the slow count, others release at once
               if (st_r.cause == RSC_CAUSE_POWER || st_r.cause == RSC_CAUSE_THR0
                   || (st_r.cause == RSC_CAUSE_THR1 && i_variant_second))
               begin
                  st_nxt.state = RSC_ST_COUNT;                      // RL1 RL5 RL10
               end
               else
               begin
                  st_nxt.state      = RSC_ST_RUN;                   // RL9 RL13 RL18
                  st_nxt.core_rst_n = 1'b1;
               end
            end
         end
         RSC_ST_COUNT:
         begin
            if (held)
            begin
               st_nxt.state   = RSC_ST_HOLD;                        // RL20
               st_nxt.rel_cnt = 6'h00;
            end
            else if (ls_tick)
            begin
               st_nxt.rel_cnt = st_r.rel_cnt + 6'h01;
               if (st_r.rel_cnt + 6'h01 == RSC_RELEASE_LAST)
               begin
                  st_nxt.state      = RSC_ST_RUN;                   // RL1 RL5
                  st_nxt.core_rst_n = 1'b1;
               end
            end
         end
         default: st_nxt.state = RSC_ST_HOLD;
      endcase
   end

   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         st_r              <= '0;
         st_r.state        <= RSC_ST_HOLD;
         st_r.option       <= 8'hFF;
         st_r.thr0_ctrl    <= RSC_THR_CTRL_RST;
         st_r.thr1_ctrl    <= RSC_THR_CTRL_RST;
         st_r.det_en       <= RSC_DETEN_RST;
         st_r.mode1        <= RSC_MODE1_RST;
         st_r.cause        <= RSC_CAUSE_POWER;
         st_r.cpu_div      <= RSC_CPU_DIV8;
         st_r.retain_rst_n <= 1'b0;
      end
      else
      begin
         st_r <= st_nxt;
      end
   end

   assign pready           = st_r.pready;
   assign pslverr          = st_r.pslverr;
   assign prdata           = st_r.prdata;
   assign o_core_reset_n   = st_r.core_rst_n;
   assign o_retain_reset_n = st_r.retain_rst_n;
   assign o_cpu_clock_div  = st_r.cpu_div;

   logic [13:0] cnt_cycles;
   always_ff @(posedge i_clock or negedge i_reset_n)
   begin
      if (!i_reset_n)
      begin
         cnt_cycles <= 14'h0000;
      end
      else if (st_r.state == RSC_ST_COUNT && st_nxt.state == RSC_ST_COUNT)
      begin
         cnt_cycles <= cnt_cycles + 14'h0001;
      end
      else
      begin
         cnt_cycles <= 14'h0000;
      end
   end

   AST_COUNT_RELEASE: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (st_r.state == RSC_ST_COUNT && st_nxt.state == RSC_ST_RUN)
      |-> (st_r.rel_cnt == RSC_RELEASE_LAST - 6'h01)) // RL1
      else $error("release before 32 slow clocks");
   AST_DIV8: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      $rose(o_core_reset_n) |-> o_cpu_clock_div == RSC_CPU_DIV8) // RL2
      else $error("cpu clock not divided by 8 after reset");
   AST_THR0_HOLD: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (thr0_armed && sup.thr0_low) |=> !o_core_reset_n) // RL4
      else $error("threshold 0 low did not reset");
   AST_THR0_COUNT: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      $rose(o_core_reset_n) && st_r.cause == RSC_CAUSE_THR0
      |-> $past(st_r.state) == RSC_ST_COUNT) // RL5
      else $error("threshold 0 released without count");
   AST_OPT_FIXED: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      $past(st_r.opt_valid) |-> $stable(st_r.option)) // RL6
      else $error("option byte changed after latch");
   AST_RETAIN: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      $fell(o_core_reset_n) |-> o_retain_reset_n) // RL8
      else $error("retained state reset by soft source");
   AST_THR1_HOLD: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (thr1_armed && sup.thr1_low) |=> !o_core_reset_n [*2]) // RL10
      else $error("threshold 1 low did not reset");
   AST_WDT: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (i_wdt_underflow && !st_r.wdt_lat && st_r.mode1[RSC_WDT_SEL_BIT] && o_core_reset_n)
      |-> ##[1:3] !o_core_reset_n) // RL14
      else $error("watchdog underflow did not reset");
   AST_SW: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      $rose(st_r.sw_req) |-> ##[1:2] !o_core_reset_n) // RL16
      else $error("software reset not taken");
   AST_PIN: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      sup.pin_low |=> !o_core_reset_n) // RL18
      else $error("reset pin low did not reset");
   AST_RESTART: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (st_r.state == RSC_ST_COUNT && held) |=> st_r.rel_cnt == 6'h00) // RL20
      else $error("release count not restarted");
   AST_COUNT_LEN: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      cnt_cycles <= 14'(RSC_RELEASE_CLOCKS * RSC_LS_TICK_CYCLES)) // RL1 RL5
      else $error("release count too long");
   AST_THR2_HOLD: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      sup.thr2_low |=> !o_core_reset_n) // RL13
      else $error("threshold 2 low did not reset");
   AST_THR1_FIRST: assert property (@(posedge i_clock) disable iff (!i_reset_n)
      (thr1_vm_armed && sup.thr1_low) |=> !o_core_reset_n) // RL9
      else $error("first variant threshold 1 low did not reset");

endmodule

`default_nettype wire

// ### bench/rsc_supply_model.sv
`timescale 1ns/1ps
`default_nettype none

// Supply comparators and the reset pin with its pull-up
module rsc_supply_model
   import rsc_pkg::*;
#(
   parameter logic [15:0] THR0_MV = 16'h09C4,
   parameter logic [15:0] THR1_MV = 16'h09F6,
   parameter logic [15:0] THR2_MV = 16'h0AF0
)
(
   input  wire logic [15:0] i_supply_mv,
   input  wire logic        i_pin_pull_low,
   output var  rsc_supply_s o_levels
);
   always_comb
   begin
      o_levels.thr0_low = (i_supply_mv <= THR0_MV);
      o_levels.thr1_low = (i_supply_mv <= THR1_MV);
      o_levels.thr2_low = (i_supply_mv <= THR2_MV);
      o_levels.pin_low  = i_pin_pull_low;
   end
endmodule

`default_nettype wire

// ### bench/reset_source_controller_tb.sv
`timescale 1ns/1ps
`default_nettype none

module reset_source_controller_tb
   import rsc_pkg::*;
;
   typedef struct packed {
      logic        wr;
      logic [11:0] a;
      logic [31:0] d;
      logic [1:0]  c;
      logic [31:0] e;
   } rsc_row_s;

   localparam int TICK = RSC_LS_TICK_CYCLES;
   localparam int LO   = (RSC_RELEASE_CLOCKS - 1) * TICK;
   localparam int HI   = (RSC_RELEASE_CLOCKS + 2) * TICK;

   logic        i_clock = 1'b0;
   logic        i_reset_n;
   logic        variant;
   logic        pin_low;
   logic        wdt_uf;
   logic        wdt_clr;
   logic        psel;
   logic        penable;
   logic        pwrite;
   logic        pready;
   logic        pslverr;
   logic        core_n;
   logic        retain_n;
   logic        er;
   logic [1:0]  div;
   logic [7:0]  option;
   logic [11:0] paddr;
   logic [15:0] supply;
   logic [31:0] pwdata;
   logic [31:0] prdata;
   logic [31:0] rd;
   rsc_supply_s lv;
   int          mismatches;
   int          cmp_count;
   int          cycles;
   int          low_cycles;
   int          retain_low;
   int          n;
   int          m;
   rsc_row_s    rows [0:11] = '{
      '{1'b0, RSC_ADDR_OPTION, 32'h0, 2'h1, 32'hDF},
      '{1'b0, RSC_ADDR_MODE1, 32'h0, 2'h1, 32'h0},
      '{1'b0, RSC_ADDR_THR0, 32'h0, 2'h1, 32'h0},
      '{1'b0, RSC_ADDR_THR1, 32'h0, 2'h1, 32'h0},
      '{1'b0, RSC_ADDR_DETEN, 32'h0, 2'h1, 32'h0},
      '{1'b0, 12'h01C, 32'h0, 2'h2, 32'h0},
      '{1'b1, RSC_ADDR_OPTION, 32'h0, 2'h0, 32'h0},
      '{1'b0, RSC_ADDR_OPTION, 32'h0, 2'h1, 32'hDF},
      '{1'b1, RSC_ADDR_THR0, 32'h41, 2'h0, 32'h0},
      '{1'b1, RSC_ADDR_DETEN, 32'h60, 2'h0, 32'h0},
      '{1'b0, RSC_ADDR_THR0, 32'h0, 2'h1, 32'h41},
      '{1'b0, RSC_ADDR_DETEN, 32'h0, 2'h1, 32'h60}};

   rsc_supply_model u_model (
      .i_supply_mv   (supply),
      .i_pin_pull_low(pin_low),
      .o_levels      (lv));

   rsc_reset_ctrl u_dut (
      .i_clock         (i_clock),
      .i_reset_n       (i_reset_n),
      .i_variant_second(variant),
      .i_option_byte   (option),
      .i_reset_pin_n   (!lv.pin_low),
      .i_thr0_low      (lv.thr0_low),
      .i_thr1_low      (lv.thr1_low),
      .i_thr2_low      (lv.thr2_low),
      .i_wdt_underflow (wdt_uf),
      .i_wdt_clear     (wdt_clr),
      .psel            (psel),
      .penable         (penable),
      .pwrite          (pwrite),
      .paddr           (paddr),
      .pwdata          (pwdata),
      .pready          (pready),
      .prdata          (prdata),
      .pslverr         (pslverr),
      .o_core_reset_n  (core_n),
      .o_retain_reset_n(retain_n),
      .o_cpu_clock_div (div));

   always #10 i_clock = !i_clock;

   task automatic results;
      if (mismatches == 0 && cmp_count > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // Cycles spent in core reset and in retained-state reset, plus the hang limit
   always @(posedge i_clock)
   begin
      cycles = cycles + 1;
      if (core_n === 1'b0)
         low_cycles = low_cycles + 1;
      if (retain_n === 1'b0)
         retain_low = retain_low + 1;
      if (cycles == 90000)
      begin
         mismatches++;
         results();
      end
   end

   task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         mismatches++;
         $display("CHECK FAILED %s expected %0h seen %0h", name, exp, got);
      end
   endtask

   task automatic tick(input int k);
      repeat (k) @(posedge i_clock);
   endtask

   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
      int w;
      w = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge i_clock);
      penable <= 1'b1;
      do
      begin
         @(posedge i_clock);
         w++;
      end
      while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("apb_answer", 32'h2, w);
      @(posedge i_clock);
   endtask

   task automatic wait_rel(input int lo, input int hi, input string name);
      int k;
      k = 0;
      while (core_n !== 1'b1 && k < hi)
      begin
         @(posedge i_clock);
         k++;
      end
      chk(name, 32'h1, k >= lo && k < hi);
   endtask

   task automatic pulse_wdt;
      wdt_uf <= 1'b1;
      tick(1);
      wdt_uf <= 1'b0;
      tick(10);
   endtask

   initial
   begin
      i_reset_n = 1'b0;
      option = 8'hDF;
      variant = 1'b0;
      supply = 16'h07D0;
      pin_low = 1'b0;
      wdt_uf = 1'b0;
      wdt_clr = 1'b1;
      psel = 1'b0;
      penable = 1'b0;
      pwrite = 1'b0;
      paddr = 12'h000;
      pwdata = 32'h0;
      mismatches = 0;
      cmp_count = 0;
      cycles = 0;
      low_cycles = 0;
      retain_low = 0;
      tick(4);
      chk("core_in_reset", 32'h0, core_n);
      chk("retain_in_reset", 32'h0, retain_n);
      chk("div_in_reset", RSC_CPU_DIV8, div);
      chk("pready_in_reset", 32'h0, pready);
      tick(4);
      i_reset_n <= 1'b1;
      tick(20);
      chk("core_supply_low", 32'h0, core_n);
      supply <= 16'h0CE4;
      wait_rel(LO, HI, "power_release");
      chk("div_after_power", RSC_CPU_DIV8, div);
      chk("retain_after_power", 32'h1, retain_n);
      tick(2);
      for (int i = 0; i < 12; i++)
      begin
         // Software sets up monitor control bits and checks the option byte is read-only
         apb(rows[i].wr, rows[i].a, rows[i].d);
         if (rows[i].c == 2'h1)
            chk("read_data", rows[i].e, rd);
         if (rows[i].c == 2'h2)
            chk("unmapped_err", 32'h1, er);
         if (rows[i].c != 2'h2)
            chk("mapped_err", 32'h0, er);
      end
      n = low_cycles;
      m = retain_low;
      apb(1'b1, RSC_ADDR_MODE0, 32'h8);
      tick(10);
      chk("sw_pulse", 32'h1, low_cycles > n && low_cycles <= n + 8);
      chk("sw_release", 32'h1, core_n);
      chk("sw_retain", m, retain_low);
      chk("sw_div", RSC_CPU_DIV8, div);
      n = low_cycles;
      pulse_wdt();
      chk("wdt_ignored", n, low_cycles);
      apb(1'b1, RSC_ADDR_MODE1, 32'h4);
      apb(1'b0, RSC_ADDR_MODE1, 32'h0);
      chk("mode1_set", 32'h4, rd);
      pulse_wdt();
      chk("wdt_pulse", 32'h1, low_cycles > n && low_cycles <= n + 8);
      chk("wdt_release", 32'h1, core_n);
      chk("wdt_retain", m, retain_low);
      apb(1'b0, RSC_ADDR_STATUS, 32'h0);
      chk("wdt_cause", 32'(RSC_CAUSE_WDT), rd);
      apb(1'b0, RSC_ADDR_MODE1, 32'h0);
      chk("mode1_cleared", 32'h0, rd);
      // A pending watchdog request holds reset until it is cleared
      apb(1'b1, RSC_ADDR_MODE1, 32'h4);
      wdt_clr <= 1'b0;
      pulse_wdt();
      chk("wdt_clear_hold", 32'h0, core_n);
      wdt_clr <= 1'b1;
      wait_rel(1, 10, "wdt_clear_release");
      pin_low <= 1'b1;
      tick(8);
      chk("pin_hold", 32'h0, core_n);
      pin_low <= 1'b0;
      wait_rel(1, 10, "pin_release");
      supply <= 16'h0A8C;
      tick(8);
      chk("thr2_hold", 32'h0, core_n);
      supply <= 16'h0CE4;
      wait_rel(1, 10, "thr2_release");
      chk("thr2_div", RSC_CPU_DIV8, div);
      supply <= 16'h07D0;
      tick(8);
      chk("thr0_hold", 32'h0, core_n);
      supply <= 16'h0CE4;
      tick(20 * TICK);
      chk("thr0_counting", 32'h0, core_n);
      supply <= 16'h07D0;
      tick(8);
      supply <= 16'h0CE4;
      wait_rel(LO, HI, "thr0_restart");
      chk("thr0_retain", m, retain_low);
      // First variant: threshold-1 reset armed by software, released at once
      apb(1'b1, RSC_ADDR_THR1, 32'h41);
      supply <= 16'h09E2;
      tick(8);
      chk("thr1_first_hold", 32'h0, core_n);
      supply <= 16'h0CE4;
      wait_rel(1, 10, "thr1_first_release");
      apb(1'b0, RSC_ADDR_STATUS, 32'h0);
      chk("thr1_first_cause", 32'(RSC_CAUSE_THR1), rd);
      i_reset_n <= 1'b0;
      option <= 8'hBF;
      variant <= 1'b1;
      supply <= 16'h07D0;
      tick(8);
      i_reset_n <= 1'b1;
      tick(100);
      chk("thr1_power_hold", 32'h0, core_n);
      supply <= 16'h0CE4;
      wait_rel(LO, HI, "thr1_power");
      option <= 8'hFF;
      tick(2);
      apb(1'b0, RSC_ADDR_OPTION, 32'h0);
      chk("option_latched", 32'hBF, rd);
      apb(1'b1, RSC_ADDR_THR1, 32'h41);
      apb(1'b1, RSC_ADDR_DETEN, 32'h40);
      apb(1'b0, RSC_ADDR_THR1, 32'h0);
      chk("thr1_ctrl_set", 32'h41, rd);
      supply <= 16'h08FC;
      tick(8);
      chk("thr1_hold", 32'h0, core_n);
      supply <= 16'h0CE4;
      wait_rel(LO, HI, "thr1_release");
      results();
   end
endmodule

`default_nettype wire
